// File: hw/fwg_regs.svh
// Register offsets, field positions, key codes and lock state codes
`ifndef FWG_REGS_SVH
`define FWG_REGS_SVH

`define FWG_PSC_ADDR 8'h8f
`define FWG_KEY_ADDR 8'hb6
`define FWG_PSC_RESET 8'h00
`define FWG_KEY_RESET 8'h00
`define FWG_BIT_SCRATCH 2
`define FWG_BIT_ERASE 1
`define FWG_BIT_WRITE 0
`define FWG_KEY_FIRST 8'ha5
`define FWG_KEY_SECOND 8'hf1
`define FWG_SCRATCH_TOP 16'h03ff
`define FWG_ST_LOCKED 2'h0
`define FWG_ST_FIRST 2'h1
`define FWG_ST_OPEN 2'h2
`define FWG_ST_DEAD 2'h3

`endif

// File: hw/fwg_pkg.sv
// Types for the flash write and erase guard
package fwg_pkg;
  typedef enum logic [1:0] {
    FWG_LOCKED,
    FWG_FIRST,
    FWG_OPEN,
    FWG_DEAD
  } fwg_lock_t;
endpackage

// File: hw/fwg_guard.sv
// Flash write and erase guard with program-store control and unlock key
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"

module fwg_guard
  import fwg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic xwr,
  input wire logic [15:0] xaddr,
  input wire logic [7:0] xwdata,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic xram_wr,
  output logic [15:0] xram_addr,
  output logic [7:0] xram_wdata,
  output logic flash_prog,
  output logic flash_erase,
  output logic flash_rd,
  output logic flash_scratch,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic flash_done,
  output logic core_stall,
  input wire logic supply_mon_en,
  input wire logic supply_rst_en,
  output logic flash_err_reset
);

  logic [2:0] psc_q;
  fwg_lock_t lock_q;
  fwg_lock_t lock_d;
  logic busy_q;
  logic [7:0] rdata_q;
  logic xram_wr_q;
  logic [15:0] xram_addr_q;
  logic [7:0] xram_wdata_q;
  logic prog_q;
  logic erase_q;
  logic [15:0] faddr_q;
  logic [7:0] fwdata_q;
  logic err_q;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] m);
    sel = (a == m);
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire psc_wr = sfr_wr && sel(sfr_addr, `FWG_PSC_ADDR);
  wire key_wr = sfr_wr && sel(sfr_addr, `FWG_KEY_ADDR);
  wire wr_en = psc_q[`FWG_BIT_WRITE];
  wire er_en = psc_q[`FWG_BIT_ERASE];
  // Core holds xwr low while stalled, so an access is never lost
  wire flash_acc = xwr && wr_en && !busy_q;
  wire supply_ok = supply_mon_en && supply_rst_en;
  // A key write in the same cycle sends the lock to the dead state and no operation starts
  wire start_op = flash_acc && lock_q == FWG_OPEN && supply_ok && !key_wr;
  wire bad_attempt = flash_acc && lock_q != FWG_OPEN;
  wire err_attempt = flash_acc && lock_q == FWG_OPEN && !supply_ok;

  // ---------------------------------------------------------------
  // Lock sequencer
  // ---------------------------------------------------------------
  always_comb begin
    lock_d = lock_q;
    case (lock_q)
      FWG_LOCKED: begin
        if (key_wr) begin
          lock_d = (sfr_wdata == `FWG_KEY_FIRST) ? FWG_FIRST : FWG_DEAD;
        end
      end
      FWG_FIRST: begin
        if (key_wr) begin
          lock_d = (sfr_wdata == `FWG_KEY_SECOND) ? FWG_OPEN : FWG_DEAD;
        end
      end
      FWG_OPEN: begin
        // Unlock is spent by one operation, even an aborted one
        if (key_wr) begin
          lock_d = FWG_DEAD;
        end else if (flash_acc) begin
          lock_d = FWG_LOCKED;
        end
      end
      FWG_DEAD: lock_d = FWG_DEAD;
      default: lock_d = FWG_DEAD;
    endcase
    if (bad_attempt) begin
      lock_d = FWG_DEAD;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_q <= FWG_LOCKED;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ---------------------------------------------------------------
  // Control register and read path
  // ---------------------------------------------------------------
  wire [7:0] psc_rd = {5'h00, psc_q};
  wire [7:0] key_rd = {6'h00, lock_q};
  wire [7:0] rd_mux = sel(sfr_addr, `FWG_PSC_ADDR) ? psc_rd :
                      sel(sfr_addr, `FWG_KEY_ADDR) ? key_rd : 8'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      psc_q <= 3'(`FWG_PSC_RESET);
      rdata_q <= 8'h00;
    end else begin
      if (psc_wr) begin
        psc_q <= sfr_wdata[2:0];
      end
      if (sfr_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data write steering and flash operation
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xram_wr_q <= 1'b0;
      xram_addr_q <= 16'h0000;
      xram_wdata_q <= 8'h00;
      busy_q <= 1'b0;
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      faddr_q <= 16'h0000;
      fwdata_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      xram_wr_q <= xwr && !wr_en;
      if (xwr && !wr_en) begin
        xram_addr_q <= xaddr;
        xram_wdata_q <= xwdata;
      end
      err_q <= err_q || err_attempt;
      // Erase wins when both enables are set; the data byte is dropped
      if (start_op) begin
        busy_q <= 1'b1;
        erase_q <= er_en;
        prog_q <= !er_en;
        faddr_q <= xaddr;
        fwdata_q <= er_en ? 8'h00 : xwdata;
      end else if (busy_q && flash_done) begin
        busy_q <= 1'b0;
        erase_q <= 1'b0;
        prog_q <= 1'b0;
      end
    end
  end

  assign sfr_rdata = rdata_q;
  assign xram_wr = xram_wr_q;
  assign xram_addr = xram_addr_q;
  assign xram_wdata = xram_wdata_q;
  assign flash_prog = prog_q;
  assign flash_erase = erase_q;
  assign flash_wdata = fwdata_q;
  assign flash_scratch = psc_q[`FWG_BIT_SCRATCH];
  // Code reads pass straight through when no operation is running
  assign flash_rd = code_rd && !busy_q;
  assign flash_addr = busy_q ? faddr_q : code_addr;
  assign core_stall = busy_q;
  assign flash_err_reset = err_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Register view, operation start, lock, error and stall
  upper_bits_zero_a: assert property (
    sfr_rd && sel(sfr_addr, `FWG_PSC_ADDR) |=> sfr_rdata[7:3] == 5'h00)
    else $error("control upper bits not zero");
  scratch_route_a: assert property (
    psc_wr && sfr_wdata[`FWG_BIT_SCRATCH] |=> flash_scratch)
    else $error("scratchpad routing wrong");
  erase_start_a: assert property (
    start_op && er_en |=> flash_erase && !flash_prog)
    else $error("erase not started");
  prog_start_a: assert property (
    start_op && !er_en |=> flash_prog && flash_wdata == $past(xwdata))
    else $error("program not started");
  unlock_seq_a: assert property (
    lock_q == FWG_FIRST && key_wr && sfr_wdata == `FWG_KEY_SECOND
    |=> lock_q == FWG_OPEN)
    else $error("unlock sequence failed");
  relock_a: assert property (
    start_op |=> lock_q == FWG_LOCKED)
    else $error("no relock after operation");
  bad_key_a: assert property (
    lock_q == FWG_LOCKED && key_wr && sfr_wdata != `FWG_KEY_FIRST
    |=> lock_q == FWG_DEAD [*3])
    else $error("bad key did not lock");
  bad_try_a: assert property (
    bad_attempt |=> lock_q == FWG_DEAD && !flash_prog && !flash_erase)
    else $error("attempt while locked not caught");
  key_read_a: assert property (
    sfr_rd && sel(sfr_addr, `FWG_KEY_ADDR) |=>
    sfr_rdata == {6'h00, $past(lock_q)})
    else $error("key read wrong");
  err_reset_a: assert property (
    err_attempt |=> flash_err_reset && !busy_q)
    else $error("no error reset");
  xram_pass_a: assert property (
    xwr && !wr_en |=> xram_wr && lock_q == $past(lock_q))
    else $error("external write disturbed");
  stall_hold_a: assert property (
    busy_q && !flash_done |=> core_stall)
    else $error("stall dropped early");

  // Key sequence and lock state codes
  first_key_a: assert property (
    lock_q == FWG_LOCKED && key_wr && sfr_wdata == `FWG_KEY_FIRST
    && !bad_attempt
    |=> lock_q == FWG_FIRST)
    else $error("first key not taken");
  open_only_a: assert property (
    $rose(busy_q) |-> $past(lock_q) == FWG_OPEN)
    else $error("operation started while locked");
  dead_hold_a: assert property (
    lock_q == FWG_DEAD |=> lock_q == FWG_DEAD)
    else $error("dead state left before reset");
  first_code_a: assert property (
    lock_q == FWG_FIRST |-> key_rd[1:0] == `FWG_ST_FIRST)
    else $error("first key code wrong");
  open_code_a: assert property (
    lock_q == FWG_OPEN |-> key_rd[1:0] == `FWG_ST_OPEN)
    else $error("unlocked code wrong");
  dead_code_a: assert property (
    lock_q == FWG_DEAD |-> key_rd[1:0] == `FWG_ST_DEAD)
    else $error("dead code wrong");

  // Routing and operation
  scratch_clear_a: assert property (
    psc_wr && !sfr_wdata[`FWG_BIT_SCRATCH] |=> !flash_scratch)
    else $error("main sector not selected");
  erase_data_a: assert property (
    start_op && er_en |=>
    flash_wdata == 8'h00 && flash_addr == $past(xaddr))
    else $error("erase address or data wrong");
  no_prog_off_a: assert property (
    xwr && !wr_en && !busy_q |=> !flash_prog && !flash_erase)
    else $error("flash touched with write enable clear");
  xram_data_a: assert property (
    xwr && !wr_en |=> xram_addr == $past(xaddr) && xram_wdata == $past(xwdata))
    else $error("external write data wrong");
  err_no_op_a: assert property (
    err_attempt |=> !flash_prog && !flash_erase)
    else $error("array programmed with supply off");
  err_sticky_a: assert property (
    flash_err_reset |=> flash_err_reset)
    else $error("error reset request dropped");
  stall_drop_a: assert property (
    busy_q && flash_done |=> !core_stall && !flash_prog && !flash_erase)
    else $error("operation did not end");
  fetch_block_a: assert property (
    core_stall |-> !flash_rd && flash_addr == faddr_q)
    else $error("code fetch during operation");

  cov_unlock_c: cover property (lock_q == FWG_FIRST ##1 lock_q == FWG_OPEN);
  cov_erase_c: cover property (start_op && er_en);
  cov_prog_c: cover property (start_op && !er_en ##[1:20] flash_done);
  cov_dead_c: cover property (bad_attempt);
  cov_err_c: cover property (err_attempt);

endmodule
`default_nettype wire

// File: verif/fwg_flash_model.sv
// Behavioural flash array that ends each operation after a delay
`timescale 1ns/1ps
`default_nettype none
module fwg_flash_model #(
  parameter int DELAY = 4
) (
  input wire logic clk_sys,
  input wire logic flash_prog,
  input wire logic flash_erase,
  output logic flash_done
);
  int cnt = 0;
  initial flash_done = 1'b0;
  // One done pulse per operation; counter keeps running so no repeat
  always @(posedge clk_sys) begin
    flash_done <= (flash_prog || flash_erase) && cnt == DELAY;
    cnt <= (flash_prog || flash_erase) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking testbench for the flash write and erase guard
`timescale 1ns/1ps
`default_nettype none
`include "fwg_regs.svh"
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic xwr = 1'b0, code_rd = 1'b1, supply_mon_en = 1'b1;
  logic supply_rst_en = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xwdata = 8'h00;
  logic [15:0] xaddr = 16'h0000, code_addr = 16'h1234;
  logic [7:0] sfr_rdata, xram_wdata, flash_wdata, rd;
  logic [15:0] xram_addr, flash_addr;
  logic xram_wr, flash_prog, flash_erase, flash_rd, flash_scratch;
  logic flash_done, core_stall, flash_err_reset;
  int error_cnt = 0, samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  fwg_guard dut (.clk_sys(clk_sys), .rst(rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xwr(xwr), .xaddr(xaddr), .xwdata(xwdata),
    .code_rd(code_rd), .code_addr(code_addr), .xram_wr(xram_wr),
    .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_rd(flash_rd), .flash_scratch(flash_scratch),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done), .core_stall(core_stall),
    .supply_mon_en(supply_mon_en), .supply_rst_en(supply_rst_en),
    .flash_err_reset(flash_err_reset));
  fwg_flash_model #(.DELAY(4)) array (.clk_sys(clk_sys),
    .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_done(flash_done));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 {sfr_rd, sfr_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1 sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic xop(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {xwr, xaddr, xwdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1 xwr = 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 50 && core_stall !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (core_stall !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH at %0t: stall never cleared", $time);
      test_done();
    end
  endtask
  task automatic unlock();
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    rd_chk(`FWG_KEY_ADDR, 8'h01);
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_SECOND);
    rd_chk(`FWG_KEY_ADDR, 8'h02);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`FWG_PSC_ADDR, 8'h00);
    rd_chk(`FWG_KEY_ADDR, 8'h00);
    rd_chk(8'h55, 8'h00);
    reg_wr(`FWG_PSC_ADDR, 8'hff);
    rd_chk(`FWG_PSC_ADDR, 8'h07);
    chk(flash_scratch, 1'b1);
    reg_wr(`FWG_PSC_ADDR, 8'h00);
    chk(flash_scratch, 1'b0);
    xop(16'h4321, 8'h5a);
    chk({xram_wr, flash_prog, xram_wdata}, 10'h25a);
    chk(xram_addr, 16'h4321);
    rd_chk(`FWG_KEY_ADDR, 8'h00);
  endtask
  task automatic t_ops();
    // Erase before programming, as software is expected to do
    unlock();
    reg_wr(`FWG_PSC_ADDR, 8'h03);
    xop(16'h0480, 8'hcc);
    chk({flash_erase, flash_prog, core_stall}, 3'h5);
    chk({flash_wdata, flash_rd}, 9'h000);
    chk(flash_addr, 16'h0480);
    wait_idle();
    chk({flash_erase, flash_rd}, 2'h1);
    chk(flash_addr, 16'h1234);
    unlock();
    reg_wr(`FWG_PSC_ADDR, 8'h05);
    xop(16'h03ff, 8'h3c);
    chk({flash_prog, flash_erase, flash_scratch}, 3'h5);
    chk({flash_addr, flash_wdata}, 24'h03ff3c);
    wait_idle();
    rd_chk(`FWG_KEY_ADDR, 8'h00);
    xop(16'h03fe, 8'h11);
    chk({flash_prog, core_stall}, 2'h0);
    rd_chk(`FWG_KEY_ADDR, 8'h03);
  endtask
  task automatic t_keys();
    do_reset();
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    rd_chk(`FWG_KEY_ADDR, 8'h03);
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_FIRST);
    reg_wr(`FWG_KEY_ADDR, `FWG_KEY_SECOND);
    rd_chk(`FWG_KEY_ADDR, 8'h03);
    do_reset();
    reg_wr(`FWG_KEY_ADDR, 8'h11);
    rd_chk(`FWG_KEY_ADDR, 8'h03);
  endtask
  task automatic t_supply();
    for (int i = 0; i < 2; i++) begin
      do_reset();
      unlock();
      {supply_mon_en, supply_rst_en} = {i[0], ~i[0]};
      reg_wr(`FWG_PSC_ADDR, 8'h01);
      xop(16'h0100, 8'h77);
      chk({flash_err_reset, flash_prog, core_stall}, 3'h4);
      rd_chk(`FWG_KEY_ADDR, 8'h00);
      {supply_mon_en, supply_rst_en} = 2'h3;
    end
    do_reset();
    chk(flash_err_reset, 1'b0);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_ops();
    t_keys();
    t_supply();
    test_done();
  end
endmodule
`default_nettype wire
